// *** rtl/mpps_top.sv ***
/*
 * Multiprocessor preemption sequencer with AHB-Lite register slave.
 * Sends preempt messages to two destinations with escalation, answers incoming
 * preempt messages, and broadcasts priority to the external filter.
 * Assumes processor events arrive as one-cycle pulses on hclk; the incoming
 * message strobe and filter answers are asynchronous pins.
 */
// Notes on behaviour
// - Broadcast interim priority on queueing instructions
// - Preempting schedule sends message to first destination
// - Receiver compares dispatch priority, suspends or resumes
// - Ack ends sequence, sender resumes
// - First nack: send to second destination
// - Second nack: resend first, raised priority
// - Raised nack: send raised to second
// - All rejected: abandon and resume
// - Suspended preempting process starts own sequence
// - Two destination words, then message word
// - Message word resets to preempt code
// - Broadcast current priority on switch, interrupt, modify
`timescale 1ns/1ps
`default_nettype none
module mpps_top
    import mpps_pkg::*;
(
    input  wire logic              hclk,          // Processor clock, 50 MHz
    input  wire logic              hresetn,       // Async reset, active low
    input  wire logic              hsel,          // Slave select
    input  wire logic [31:0]       haddr,         // Byte address
    input  wire logic [1:0]        htrans,        // Transfer type
    input  wire logic              hwrite,        // Write when high
    input  wire logic [2:0]        hsize,         // Word only
    input  wire logic [31:0]       hwdata,        // Write data
    input  wire logic              hready,        // Bus ready
    output logic [31:0]            hrdata,        // Read data
    output logic                   hreadyout,     // Slave ready
    output logic                   hresp,         // Always OKAY
    input  wire logic              sched_preempt, // Preempting process scheduled
    input  wire logic [PRIO_W-1:0] sched_prio,    // Its priority
    input  wire logic [PRIO_W-1:0] cur_prio,      // Current process priority
    input  wire logic              evt_queue_op,  // Send/signal/schedule instruction
    input  wire logic              evt_switch,    // Process switch
    input  wire logic              evt_intr,      // Interrupt not from a message
    input  wire logic              evt_modify,    // Modify process controls
    input  wire logic              rx_iac_n,      // Incoming message strobe, pin
    input  wire logic              cpu_intr,      // Processor is interrupted
    input  wire logic              cpu_stopped,   // Processor is stopped
    input  wire logic [PRIO_W-1:0] dispatch_prio, // Top priority at dispatch port
    input  wire logic              susp_is_preempt,// Current process may preempt
    output logic                   rx_suspend,    // Pulse: suspend and dispatch
    output logic                   rx_resume,     // Pulse: keep current process
    output logic                   seq_resume,    // Pulse: sequence over, resume
    output logic                   xprio_valid,   // Pulse: priority broadcast
    output logic [PRIO_W-1:0]      xprio_value,   // Broadcast priority
    output logic                   iac_valid,     // Outgoing message on bus
    output logic [31:0]            iac_addr,      // Outgoing address word
    output logic [31:0]            iac_data,      // Outgoing message word
    input  wire logic              iac_ack,       // Filter accepted, pin
    input  wire logic              iac_nack       // Filter rejected, pin
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [1:0]         ctrl_r;     // Enables
    logic [31:0]        dest0_r;    // First destination
    logic [31:0]        dest1_r;    // Second destination
    logic [31:0]        msg_r;      // Message word
    logic [PRIO_W-1:0]  interim_r;  // Interim priority
    logic [PRIO_W-1:0]  nplim_r;    // Nonpreempt limit
    logic [PRIO_W-1:0]  raise_r;    // Preempting process priority
    mpps_state_t        state_r;    // Sequencer state
    mpps_outcome_t      outcome_r;  // Last outcome
    logic               wr_pend_r;  // Write data phase pending
    logic [7:0]         wr_ofs_r;   // Write offset
    logic [SYNC_STAGES-1:0] rx_sync_r; // Incoming strobe synchroniser
    logic               rx_prev_r;  // Previous synchronised strobe
    logic               rx_evt;     // Incoming message edge
    logic               rx_take;    // Receiver suspends
    logic               start;      // Start a sequence
    logic               ap_valid;   // Address phase accepted
    mpps_msg_if         mi ();      // Sender channel

    // ****************************************************************
    // Register bus
    // ****************************************************************
    assign ap_valid = hsel && hready && htrans[1];
    assign hresp    = 1'b0;

    // Capture write address, zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_ofs_r  <= '0;
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
            wr_pend_r <= ap_valid && hwrite;
            wr_ofs_r  <= haddr[7:0];
        end
    end

    // Software registers, written in data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r    <= CTRL_RST;
            dest0_r   <= DEST_RST;
            dest1_r   <= DEST_RST;
            msg_r     <= MSG_RST;
            interim_r <= PRIO_RST;
            nplim_r   <= PRIO_RST;
        end else if (wr_pend_r) begin
            unique case (wr_ofs_r)
                OFS_CTRL:    ctrl_r    <= hwdata[1:0];
                OFS_DEST0:   dest0_r   <= hwdata;
                OFS_DEST1:   dest1_r   <= hwdata;
                OFS_MSG:     msg_r     <= hwdata;
                OFS_INTERIM: interim_r <= hwdata[PRIO_W-1:0];
                OFS_NPLIM:   nplim_r   <= hwdata[PRIO_W-1:0];
                default:     ;  // Read-only or unmapped: ignored
            endcase
        end
    end

    // Read data registered at address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (ap_valid && !hwrite) begin
            unique case (haddr[7:0])
                OFS_CTRL:    hrdata <= {30'h0, ctrl_r};
                OFS_DEST0:   hrdata <= dest0_r;
                OFS_DEST1:   hrdata <= dest1_r;
                OFS_MSG:     hrdata <= msg_r;
                OFS_INTERIM: hrdata <= {27'h0, interim_r};
                OFS_NPLIM:   hrdata <= {27'h0, nplim_r};
                OFS_CURPRIO: hrdata <= {27'h0, cur_prio};
                OFS_STATUS:  hrdata <= {24'h0, mi.busy, outcome_r, 2'h0, state_r};
                default:     hrdata <= '0; // Unmapped reads zero
            endcase
        end
    end

    // ****************************************************************
    // Receiver side
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_sync_r <= '0;
            rx_prev_r <= 1'b0;
        end else begin
            rx_sync_r <= {rx_sync_r[SYNC_STAGES-2:0], ~rx_iac_n};
            rx_prev_r <= rx_sync_r[SYNC_STAGES-1];
        end
    end
    assign rx_evt  = rx_sync_r[SYNC_STAGES-1] && !rx_prev_r;
    assign rx_take = (dispatch_prio > cur_prio) || (dispatch_prio > nplim_r);

    // Suspend or resume on an incoming message
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_suspend <= 1'b0;
            rx_resume  <= 1'b0;
        end else begin
            rx_suspend <= rx_evt && !cpu_intr && !cpu_stopped && rx_take;
            rx_resume  <= rx_evt && !cpu_intr && !cpu_stopped && !rx_take;
        end
    end

    // ****************************************************************
    // Preemption sequencer
    // ****************************************************************
    assign start = ctrl_r[CTRL_MPEN] && state_r == MPPS_IDLE
                   && (sched_preempt || (rx_suspend && susp_is_preempt));

    // Escalation through both destinations at both priorities
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r    <= MPPS_IDLE;
            raise_r    <= PRIO_RST;
            outcome_r  <= MPPS_OUT_NONE;
            seq_resume <= 1'b0;
            mi.req     <= 1'b0;
            mi.addr    <= '0;
            mi.data    <= '0;
        end else begin
            seq_resume <= 1'b0;
            mi.req     <= 1'b0;
            mi.data    <= msg_r;
            unique case (state_r)
                MPPS_IDLE: if (start) begin
                    raise_r <= sched_preempt ? sched_prio : cur_prio;
                    mi.req  <= 1'b1;
                    mi.addr <= dest0_r;
                    state_r <= MPPS_D0_O;
                end
                default: if (mi.done_ack) begin
                    outcome_r  <= MPPS_OUT_ACCEPT;
                    seq_resume <= 1'b1;
                    state_r    <= MPPS_IDLE;
                end else if (mi.done_nack) begin
                    unique case (state_r)
                        MPPS_D0_O: begin
                            mi.req  <= 1'b1;
                            mi.addr <= dest1_r;
                            state_r <= MPPS_D1_O;
                        end
                        MPPS_D1_O: begin
                            mi.req  <= 1'b1;
                            mi.addr <= mpps_set_prio(dest0_r, raise_r);
                            state_r <= MPPS_D0_R;
                        end
                        MPPS_D0_R: begin
                            mi.req  <= 1'b1;
                            mi.addr <= mpps_set_prio(dest1_r, raise_r);
                            state_r <= MPPS_D1_R;
                        end
                        default: begin
                            outcome_r  <= MPPS_OUT_ABANDON;
                            seq_resume <= 1'b1;
                            state_r    <= MPPS_IDLE;
                        end
                    endcase
                end
            endcase
        end
    end

    // ****************************************************************
    // External priority broadcast
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xprio_valid <= 1'b0;
            xprio_value <= PRIO_RST;
        end else begin
            xprio_valid <= 1'b0;
            if (ctrl_r[CTRL_XPEN]) begin
                if (evt_switch || evt_intr || evt_modify) begin
                    xprio_valid <= 1'b1;
                    xprio_value <= cur_prio;
                end else if (evt_queue_op) begin
                    xprio_valid <= 1'b1;
                    xprio_value <= interim_r;
                end
            end
        end
    end

    // ****************************************************************
    // Message sender
    // ****************************************************************
    mpps_sender u_sender (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .mi        (mi),
        .iac_valid (iac_valid),
        .iac_addr  (iac_addr),
        .iac_data  (iac_data),
        .iac_ack   (iac_ack),
        .iac_nack  (iac_nack)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_first_dest: assert property (start |=> mi.req && mi.addr == dest0_r)
        else $error("sequence did not start at first destination");
    a_second_dest: assert property (state_r == MPPS_D0_O && mi.done_nack
        |=> state_r == MPPS_D1_O && mi.addr == dest1_r)
        else $error("first nack did not go to second destination");
    a_raise_first: assert property (state_r == MPPS_D1_O && mi.done_nack
        |=> mi.addr[PRIO_LSB +: PRIO_W] == raise_r && state_r == MPPS_D0_R)
        else $error("raised resend missing");
    a_raise_second: assert property (state_r == MPPS_D0_R && mi.done_nack
        |=> state_r == MPPS_D1_R && mi.addr[PRIO_LSB +: PRIO_W] == raise_r)
        else $error("raised send to second missing");
    a_abandon: assert property (state_r == MPPS_D1_R && mi.done_nack
        |=> seq_resume && state_r == MPPS_IDLE && outcome_r == MPPS_OUT_ABANDON)
        else $error("abandon not taken");
    a_ack_ends: assert property (state_r != MPPS_IDLE && mi.done_ack
        |=> seq_resume && state_r == MPPS_IDLE)
        else $error("ack did not end sequence");
    a_single_out: assert property (mi.busy |-> !mi.req)
        else $error("second message while one outstanding");
    a_broadcast: assert property (ctrl_r[CTRL_XPEN] && evt_queue_op && !evt_switch
        && !evt_intr && !evt_modify |=> xprio_valid && xprio_value == interim_r)
        else $error("interim priority not broadcast");
    a_bcast_cur: assert property (ctrl_r[CTRL_XPEN] && evt_switch
        |=> xprio_valid && xprio_value == $past(cur_prio))
        else $error("current priority not broadcast");
    a_rx_decide: assert property (rx_suspend |-> !rx_resume)
        else $error("receiver both suspends and resumes");

    c_accept_first: cover property (state_r == MPPS_D0_O && mi.done_ack);
    c_abandon: cover property (state_r == MPPS_D1_R && mi.done_nack);
    c_chain: cover property (rx_suspend && susp_is_preempt && start);
endmodule : mpps_top
`default_nettype wire

// *** rtl/mpps_pkg.sv ***
/*
 * Constants shared by the preemption sequencer, its message sender and the bus slave.
 * Assumes a 32-bit register bus and a 5-bit process priority held in the low bits
 * of each destination address word.
 */
package mpps_pkg;
    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0]  OFS_CTRL    = 8'h00; // Enables
    localparam logic [7:0]  OFS_DEST0   = 8'h04; // First destination word
    localparam logic [7:0]  OFS_DEST1   = 8'h08; // Second destination word
    localparam logic [7:0]  OFS_MSG     = 8'h0C; // Message word
    localparam logic [7:0]  OFS_INTERIM = 8'h10; // Interim priority
    localparam logic [7:0]  OFS_NPLIM   = 8'h14; // Nonpreempt limit
    localparam logic [7:0]  OFS_CURPRIO = 8'h18; // Current priority, read only
    localparam logic [7:0]  OFS_STATUS  = 8'h1C; // Sequencer status, read only

    // ****************************************************************
    // Fields and reset values
    // ****************************************************************
    localparam int          PRIO_W      = 5;         // Priority width
    localparam int          PRIO_LSB    = 0;         // Priority field in address word
    localparam int          CTRL_MPEN   = 0;         // Multiprocessor preempt enable
    localparam int          CTRL_XPEN   = 1;         // External priority broadcast enable
    localparam logic [31:0] MSG_RST     = 32'h85000000; // Preempt process message code
    localparam logic [31:0] DEST_RST    = 32'h00000000; // Destination words after reset
    localparam logic [1:0]  CTRL_RST    = 2'h0;      // Both enables off
    localparam logic [4:0]  PRIO_RST    = 5'h00;     // Priority fields after reset
    localparam int          SYNC_STAGES = 2;         // Pin synchroniser depth

    // ****************************************************************
    // Sequencer states, Gray along the escalation path
    // ****************************************************************
    typedef enum logic [2:0] {
        MPPS_IDLE = 3'b000,
        MPPS_D0_O = 3'b001,
        MPPS_D1_O = 3'b011,
        MPPS_D0_R = 3'b010,
        MPPS_D1_R = 3'b110
    } mpps_state_t;

    // Outcome of the last preemption attempt
    typedef enum logic [1:0] {
        MPPS_OUT_NONE    = 2'h0,
        MPPS_OUT_ACCEPT  = 2'h1,
        MPPS_OUT_ABANDON = 2'h2
    } mpps_outcome_t;

    // Replace the priority field of an address word
    function automatic logic [31:0] mpps_set_prio(input logic [31:0] w,
                                                  input logic [PRIO_W-1:0] p);
        logic [31:0] r;
        r = w;
        r[PRIO_LSB +: PRIO_W] = p;
        return r;
    endfunction : mpps_set_prio
endpackage : mpps_pkg

// *** rtl/mpps_msg_if.sv ***
/*
 * Request channel between the sequencer and the message sender.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface mpps_msg_if;
    logic        req;      // One-cycle request
    logic [31:0] addr;     // Destination address word
    logic [31:0] data;     // Message word
    logic        busy;     // Message outstanding
    logic        done_ack; // Pulse: accepted
    logic        done_nack;// Pulse: rejected
    modport seq (output req, addr, data, input busy, done_ack, done_nack);
    modport snd (input req, addr, data, output busy, done_ack, done_nack);
endinterface : mpps_msg_if
`default_nettype wire

// *** rtl/mpps_sender.sv ***
/*
 * Message sender: drives one message onto the bus pins and holds it until the
 * remote filter answers with ACK or NACK.
 * Assumes ACK and NACK arrive as levels from another domain, held until valid drops.
 */
`timescale 1ns/1ps
`default_nettype none
module mpps_sender
    import mpps_pkg::*;
(
    input  wire logic  hclk,       // Processor clock
    input  wire logic  hresetn,    // Async reset, active low
    mpps_msg_if.snd    mi,         // Sequencer side
    output logic        iac_valid,  // Message on bus
    output logic [31:0] iac_addr,   // Destination address word
    output logic [31:0] iac_data,   // Message word
    input  wire logic   iac_ack,    // Filter accepted, pin
    input  wire logic   iac_nack    // Filter rejected, pin
);
    logic [SYNC_STAGES-1:0] ack_sync_r;  // Ack synchroniser
    logic [SYNC_STAGES-1:0] nack_sync_r; // Nack synchroniser
    logic                   ack_s;       // Synchronised ack
    logic                   nack_s;      // Synchronised nack
    logic                   pend_r;      // Request waiting for old answer to clear

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_sync_r  <= '0;
            nack_sync_r <= '0;
        end else begin
            ack_sync_r  <= {ack_sync_r[SYNC_STAGES-2:0], iac_ack};
            nack_sync_r <= {nack_sync_r[SYNC_STAGES-2:0], iac_nack};
        end
    end
    assign ack_s  = ack_sync_r[SYNC_STAGES-1];
    assign nack_s = nack_sync_r[SYNC_STAGES-1];

    // ****************************************************************
    // One outstanding message, held until answered
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            iac_valid    <= 1'b0;
            iac_addr     <= '0;
            iac_data     <= '0;
            pend_r       <= 1'b0;
            mi.done_ack  <= 1'b0;
            mi.done_nack <= 1'b0;
        end else begin
            mi.done_ack  <= 1'b0;
            mi.done_nack <= 1'b0;
            if (iac_valid) begin
                if (ack_s) begin // Accepted: drop message
                    iac_valid   <= 1'b0;
                    mi.done_ack <= 1'b1;
                end else if (nack_s) begin // Rejected: drop message
                    iac_valid    <= 1'b0;
                    mi.done_nack <= 1'b1;
                end
            end else if ((mi.req || pend_r) && !ack_s && !nack_s) begin // Old answer gone
                iac_valid <= 1'b1;
                iac_addr  <= mi.addr;
                iac_data  <= mi.data;
                pend_r    <= 1'b0;
            end else if (mi.req) begin // Old answer still high: keep request
                pend_r    <= 1'b1;
            end
        end
    end
    assign mi.busy = iac_valid | pend_r | mi.done_ack | mi.done_nack;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_msg_held: assert property (@(posedge hclk) disable iff (!hresetn)
        iac_valid && !ack_s && !nack_s |=> iac_valid && $stable(iac_addr))
        else $error("message dropped before answer");
    a_answer_once: assert property (@(posedge hclk) disable iff (!hresetn)
        !(mi.done_ack && mi.done_nack))
        else $error("ack and nack reported together");
endmodule : mpps_sender
`default_nettype wire

// *** tb/mpps_filter_model.sv ***
/* Priority filter model for the far side of the outgoing message link.
   Assumes one message at a time; address bit 8 picks the receiver. */
`timescale 1ns/1ps
`default_nettype none
module mpps_filter_model (
    input  wire logic        hclk,      // Clock
    input  wire logic        hresetn,   // Reset, active low
    input  wire logic        iac_valid, // Message on bus
    input  wire logic [31:0] iac_addr,  // Address word
    input  wire logic [4:0]  rprio0,    // Receiver 0 priority
    input  wire logic [4:0]  rprio1,    // Receiver 1 priority
    input  wire logic [3:0]  lat,       // Answer delay
    output logic             iac_ack,   // Accepted
    output logic             iac_nack   // Rejected
);
    // ****
    // Answer logic
    // ****
    logic [3:0] cnt_r; // Cycles waited
    logic [4:0] rp;    // Addressed receiver priority
    assign rp = iac_addr[8] ? rprio1 : rprio0;
    // Answer once, release as soon as the message drops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {iac_ack, iac_nack, cnt_r} <= '0;
        end else if (!iac_valid) begin
            {iac_ack, iac_nack, cnt_r} <= '0;
        end else if (cnt_r != lat) begin
            cnt_r <= cnt_r + 4'h1;
        end else if (!(iac_ack | iac_nack)) begin
            iac_ack  <= iac_addr[4:0] > rp;
            iac_nack <= !(iac_addr[4:0] > rp);
        end
    end
endmodule : mpps_filter_model
`default_nettype wire

// *** tb/mpps_bench.sv ***
/* Self-checking bench for the preemption sequencer.
   Assumes the filter model on the message link and a zero-wait slave. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module mpps_bench;
    import mpps_pkg::*;
    localparam logic [31:0] D0 = 32'h00000001; // Receiver 0, priority 1
    localparam logic [31:0] D1 = 32'h00000101; // Receiver 1, priority 1
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, vld_q, stp;
    logic        sched_preempt, rx_iac_n, cpu_intr, susp_is_preempt;
    logic        iac_valid, iac_ack, iac_nack, rx_suspend, rx_resume, seq_resume, xprio_valid;
    logic [31:0] haddr, hwdata, hrdata, iac_addr, iac_data, rd;
    logic [1:0]  htrans;
    logic [3:0]  ev, lat;
    logic [4:0]  sched_prio, cur_prio, dispatch_prio, xprio_value, rp0, rp1;
    logic [31:0] log_q[$];
    int          num_errors, checked, cyc;
    mpps_top i_mpps_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sched_preempt,
        .sched_prio, .cur_prio, .evt_queue_op(ev[0]), .evt_switch(ev[1]), .evt_intr(ev[2]),
        .evt_modify(ev[3]), .rx_iac_n, .cpu_intr, .cpu_stopped(stp), .dispatch_prio,
        .susp_is_preempt, .rx_suspend, .rx_resume, .seq_resume, .xprio_valid, .xprio_value,
        .iac_valid, .iac_addr, .iac_data, .iac_ack, .iac_nack);
    mpps_filter_model i_mpps_filter_model (.hclk, .hresetn, .iac_valid, .iac_addr,
        .rprio0(rp0), .rprio1(rp1), .lat, .iac_ack, .iac_nack);
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // Log each new message, cut a hang short
    always @(posedge hclk) begin
        vld_q <= iac_valid;
        if (iac_valid && !vld_q) begin
            log_q.push_back(iac_addr);
            `CHK("iac_data", MSG_RST, iac_data);
        end
        cyc++;
        if (cyc > 30000) begin
            num_errors++;
            results();
        end
    end
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp);
    endtask : ahb
    task seq(input logic [3:0] l, input logic [4:0] sp, a, b, input int n, input logic [1:0] oc);
        logic [31:0] ex[4];
        ex = '{D0, D1, {D0[31:5], sp}, {D1[31:5], sp}};
        log_q = {}; lat <= l; rp0 <= a; rp1 <= b; sched_prio <= sp; sched_preempt <= 1'b1;
        @(posedge hclk) sched_preempt <= 1'b0;
        repeat (300) begin @(posedge hclk); if (seq_resume === 1'b1) break; end
        `CHK("msg_count", n, log_q.size());
        for (int i = 0; i < n; i++) `CHK("iac_addr", ex[i], log_q[i]);
        ahb(1'b0, OFS_STATUS, 32'h0);
        `CHK("outcome", oc, rd[6:5]);
    endtask : seq
    task rx(input logic [4:0] d, c, input logic i, s, input logic [1:0] e);
        logic [1:0] got;
        got = 2'b00; dispatch_prio <= d; cur_prio <= c; cpu_intr <= i;
        susp_is_preempt <= s; rx_iac_n <= 1'b0;
        repeat (8) begin @(posedge hclk); got = got | {rx_suspend, rx_resume}; end
        rx_iac_n <= 1'b1;
        repeat (4) @(posedge hclk);
        `CHK("rx_action", e, got);
    endtask : rx
    task results();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    initial begin
        {hresetn, hsel, haddr, htrans, hwrite, hwdata, ev, sched_preempt, cpu_intr} = '0;
        {susp_is_preempt, sched_prio, cur_prio, dispatch_prio, rp0, rp1, stp} = '0;
        rx_iac_n = 1'b1; lat = 4'h1; num_errors = 0; checked = 0; cyc = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, OFS_MSG, 32'h0);
        `CHK("msg_reset", MSG_RST, rd);
        ahb(1'b1, OFS_DEST0, D0);
        ahb(1'b1, OFS_DEST1, D1);
        seq(4'h1, 5'h14, 5'h00, 5'h00, 0, 2'h0);
        ahb(1'b1, OFS_CTRL, 32'h1);
        seq(4'h1, 5'h14, 5'h00, 5'h0A, 1, 2'h1);
        seq(4'h1, 5'h14, 5'h0A, 5'h0A, 3, 2'h1);
        seq(4'h6, 5'h14, 5'h19, 5'h19, 4, 2'h2);
        ahb(1'b1, OFS_NPLIM, 32'h1F);
        rp0 <= 5'h00; log_q = {};
        rx(5'h09, 5'h05, 1'b0, 1'b1, 2'b10);
        repeat (40) @(posedge hclk);
        `CHK("rx_seq", D0, log_q[0]);
        rx(5'h09, 5'h0C, 1'b0, 1'b0, 2'b01);
        rx(5'h1F, 5'h00, 1'b1, 1'b0, 2'b00);
        stp <= 1'b1;
        rx(5'h1F, 5'h00, 1'b0, 1'b0, 2'b00);
        stp <= 1'b0;
        ahb(1'b1, OFS_CTRL, 32'h2);
        ahb(1'b1, OFS_INTERIM, 32'h1B);
        cur_prio <= 5'h07;
        for (int k = 0; k < 4; k++) begin
            ev[k] <= 1'b1;
            @(posedge hclk) ev <= 4'h0;
            @(posedge hclk);
            `CHK("xprio", {1'b1, (k == 0) ? 5'h1B : 5'h07}, {xprio_valid, xprio_value});
        end
        results();
    end
endmodule : mpps_bench
`default_nettype wire
